// [verilog/rae_edge_timing.sv]
// rectifier and auxiliary edge timing with wishbone register access
// Functional notes
// - edge time is 12 bits: timing byte on top, setting bits [7:4] below
// - one count of an edge time is a 5 ns step of position
// - setting bit 3 high shifts the edge by loop modulation, else fixed
// - setting bit 2 high: more modulation moves edge later; low: earlier
// - rectifier soft start only while first rectifier fall setting bit 0 set
// - that byte's bit 1 high: soft start every enable, else only until a ramp completes
// - first rectifier fall edge placed by time in bytes 0x53 and 0x54
// - second rectifier rise uses 0x55/0x56, its fall uses 0x57/0x58
// - auxiliary rise placed by time in bytes 0x59 and 0x5A
// - timing writes take effect only when the latch strobe is written
`timescale 1ns/100ps
module rae_edge_timing #(
    parameter int MOD_W     = 8,
    parameter int RAMP_STEP = 16
) (
    // clock and reset
    input  wire logic             I_CLK,
    input  wire logic             I_RSTN,
    // wishbone slave
    input  wire logic             I_WB_CYC,
    input  wire logic             I_WB_STB,
    input  wire logic             I_WB_WE,
    input  wire logic [8:0]       I_WB_ADR,
    input  wire logic [3:0]       I_WB_SEL,
    input  wire logic [31:0]      I_WB_DAT,
    output logic      [31:0]      O_WB_DAT,
    output logic                  O_WB_ACK,
    // pwm unit side
    input  wire logic             I_PERIOD_START,
    input  wire logic [MOD_W-1:0] I_MODULATION,
    input  wire logic             I_RECT_ENABLE,
    input  wire logic             I_RECT1_RISE,
    input  wire logic             I_AUX_FALL,
    // gate drive outputs
    output logic                  O_RECT1,
    output logic                  O_RECT2,
    output logic                  O_AUX
);

    // timing bytes: written copy and the copy that drives the edges
    logic [7:0]  shadow_q [rae_pkg::NUM_BYTES];
    logic [7:0]  active_q [rae_pkg::NUM_BYTES];

    // bus slave state and decode
    logic        ack_q;
    logic [31:0] rdat_q;
    logic [6:0]  idx;
    logic        req;
    logic        wr_en;
    logic        in_range;
    logic [2:0]  slot;
    logic        go_wr;
    logic        pending;
    logic [7:0]  status;

    // period timebase
    logic [11:0] cnt_q;
    logic [7:0]  pre_q;
    logic        step;

    // per-edge targets and matches
    logic [11:0] target [rae_pkg::NUM_EDGES];
    logic        hit [rae_pkg::NUM_EDGES];

    // output latches
    logic        r1_q;
    logic        r2_q;
    logic        aux_q;

    // rectifier enable tracking and soft start
    logic        en_d1_q;
    logic        en_rise;
    logic        ramping_q;
    logic        first_done_q;
    logic [11:0] ramp_q;
    logic        ramp_gate;
    logic        ramp_on;
    logic        ramp_every;
    logic        ramp_start;
    logic        ramp_last;
    logic        rect_allow;

    // bus request decode; a request is taken only while ack is low
    assign idx      = I_WB_ADR[8:2];
    assign req      = I_WB_CYC & I_WB_STB & ~ack_q;
    assign wr_en    = req & I_WB_WE & I_WB_SEL[0];
    // only the eight timing and setting bytes have storage
    assign in_range = (idx >= rae_pkg::IDX_FIRST) && (idx <= rae_pkg::IDX_AUX_RISE_SET);
    assign slot     = 3'(idx - rae_pkg::IDX_FIRST);
    // the strobe is not stored, so the latch register always reads zero
    // byte lane 0 must be selected for the strobe as for any other write
    assign go_wr = wr_en & (idx == rae_pkg::IDX_LATCH) & I_WB_DAT[rae_pkg::LATCH_GO];

    // shadow bytes written by software, pending until latched
    // a write outside the range or with lane 0 off leaves every byte alone
    // reads return this copy, so software sees what it wrote before latching
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            for (int i = 0; i < rae_pkg::NUM_BYTES; i++) begin
                shadow_q[i] <= rae_pkg::RST_BYTE;
            end
        end else if (wr_en && in_range) begin
            shadow_q[slot] <= I_WB_DAT[7:0];
        end
    end

    // active bytes copied from shadow only on the latch strobe
    // all bytes move together so an edge never mixes an old and a new half
    // live edits to a running supply therefore never show a half-set time
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            for (int i = 0; i < rae_pkg::NUM_BYTES; i++) begin
                active_q[i] <= rae_pkg::RST_BYTE;
            end
        end else if (go_wr) begin
            for (int i = 0; i < rae_pkg::NUM_BYTES; i++) begin
                active_q[i] <= shadow_q[i];
            end
        end
    end

    // any shadow byte differing from its active copy
    // shown in status so software can see an edit still waiting for the strobe
    always_comb begin
        pending = 1'b0;
        for (int i = 0; i < rae_pkg::NUM_BYTES; i++) begin
            if (shadow_q[i] != active_q[i]) begin
                pending = 1'b1;
            end
        end
    end

    // acknowledge one cycle after the request, dropped the next cycle
    // the ack gate in req keeps a held strobe from being taken twice
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // status word assembled from live state; spare bits read zero
    // outputs read back as their latches, before enable and ramp gating
    always_comb begin
        status                          = 8'h00;
        status[rae_pkg::STS_R1]         = r1_q;
        status[rae_pkg::STS_R2]         = r2_q;
        status[rae_pkg::STS_AUX]        = aux_q;
        status[rae_pkg::STS_RAMPING]    = ramping_q;
        status[rae_pkg::STS_FIRST_DONE] = first_done_q;
        status[rae_pkg::STS_PENDING]    = pending;
    end

    // read data registered with the acknowledge; unmapped reads zero
    // upper bits stay zero since every register is one byte wide
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rdat_q <= 32'h0000_0000;
        end else if (req) begin
            rdat_q <= 32'h0000_0000;
            if (in_range) begin
                rdat_q[7:0] <= shadow_q[slot];
            end else if (idx == rae_pkg::IDX_STATUS) begin
                rdat_q[7:0] <= status;
            end
        end
    end

    // bus outputs straight from their flip-flops
    assign O_WB_ACK = ack_q;
    assign O_WB_DAT = rdat_q;

    // step prescaler: one period-counter step per 5 ns
    // at a 5 ns clock the step fires every cycle; a faster clock divides down
    // a period start realigns the prescaler so edges keep their phase
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            pre_q <= 8'h00;
        end else if (I_PERIOD_START || step) begin
            pre_q <= 8'h00;
        end else begin
            pre_q <= pre_q + 8'h01;
        end
    end

    assign step = (pre_q == 8'(rae_pkg::STEP_CYC - 1));

    // period counter restarts at each period start, holds at full scale
    // holding stops an overlong period from wrapping back onto early edges
    // an edge set at full scale therefore keeps matching until the next start
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            cnt_q <= rae_pkg::RST_TIME;
        end else if (I_PERIOD_START) begin
            cnt_q <= rae_pkg::RST_TIME;
        end else if (step && cnt_q != rae_pkg::TIME_MAX) begin
            cnt_q <= cnt_q + 12'h001;
        end
    end

    // per-edge target time and match
    generate
        for (genvar e = 0; e < rae_pkg::NUM_EDGES; e++) begin : g_edge
            logic [7:0]  time_b;
            logic [7:0]  set_b;
            logic [11:0] base;
            logic [12:0] later;
            logic [12:0] mod_ext;
            logic [11:0] earlier;
            logic        under;
            // timing byte sits at the even slot, its setting byte right after it
            assign time_b  = active_q[2*e];
            assign set_b   = active_q[2*e+1];
            // upper byte from timing, lower nibble from setting
            assign base    = {time_b,
                              set_b[rae_pkg::SET_LSB_HI:rae_pkg::SET_LSB_LO]};
            // one bit of headroom so a late edge can be seen passing full scale
            assign mod_ext = 13'(I_MODULATION);
            assign later   = {1'b0, base} + mod_ext;
            // an early edge must not wrap round to the end of the period
            assign under   = mod_ext > {1'b0, base};
            assign earlier = 12'({1'b0, base} - mod_ext);
            always_comb begin
                if (!set_b[rae_pkg::SET_MOD_EN]) begin
                    target[e] = base;
                end else if (set_b[rae_pkg::SET_MOD_SIGN]) begin
                    // modulation moves the edge later, clamped at full scale
                    target[e] = later[12] ? rae_pkg::TIME_MAX : later[11:0];
                end else if (under) begin
                    // modulation moves the edge earlier, clamped at zero
                    target[e] = rae_pkg::RST_TIME;
                end else begin
                    target[e] = earlier;
                end
            end
            assign hit[e] = step && (cnt_q == target[e]);
        end
    endgenerate

    // soft start configuration from the first rectifier fall setting
    assign ramp_on    = active_q[1][rae_pkg::SET_RAMP_ON];
    assign ramp_every = active_q[1][rae_pkg::SET_RAMP_EVERY];

    // rectifier enable edge detect (same-clock input)
    // the enable comes from logic on this clock, so no synchroniser is needed
    // the register resets low, matching a disabled input: no false edge
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            en_d1_q <= 1'b0;
        end else begin
            en_d1_q <= I_RECT_ENABLE;
        end
    end

    assign en_rise = I_RECT_ENABLE & ~en_d1_q;

    // a ramp starts on each enable until one ramp has completed, or on every enable when asked
    assign ramp_start = ramp_on && (ramp_every || !first_done_q);
    // the ramp ends once one more step would pass full scale
    assign ramp_last  = ramp_q > (rae_pkg::TIME_MAX - 12'(RAMP_STEP));

    // soft start: conduction window grows by one step per period
    // a ramp cut short by disable does not count as the first one done
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ramping_q    <= 1'b0;
            ramp_q       <= rae_pkg::RST_TIME;
            first_done_q <= 1'b0;
        end else if (en_rise) begin
            ramping_q <= ramp_start;
            ramp_q    <= rae_pkg::RST_TIME;
        end else if (!ramp_on || !I_RECT_ENABLE) begin
            ramping_q <= 1'b0;
        end else if (ramping_q && I_PERIOD_START) begin
            if (ramp_last) begin
                ramping_q    <= 1'b0;
                first_done_q <= 1'b1;
            end else begin
                ramp_q <= ramp_q + 12'(RAMP_STEP);
            end
        end
    end

    // during a ramp the rectifiers conduct only early in the period
    // the window opens from period start, so the fall edge is cut first
    assign ramp_gate = !ramping_q || (cnt_q < ramp_q);

    // first rectifier: rises on the external edge, falls at its own time
    // the fall wins a tie so a late rise pulse cannot stretch conduction
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            r1_q <= 1'b0;
        end else if (hit[rae_pkg::EDGE_R1_FALL]) begin
            r1_q <= 1'b0;
        end else if (I_RECT1_RISE) begin
            r1_q <= 1'b1;
        end
    end

    // second rectifier: both edges timed here, fall wins a tie
    // favouring the fall keeps the switch off when both times coincide
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            r2_q <= 1'b0;
        end else if (hit[rae_pkg::EDGE_R2_FALL]) begin
            r2_q <= 1'b0;
        end else if (hit[rae_pkg::EDGE_R2_RISE]) begin
            r2_q <= 1'b1;
        end
    end

    // auxiliary: rise timed here, fall comes from the rest of the unit
    // the external fall wins a tie so the drive is never left on too long
    // the auxiliary drive has no soft start and no enable gating here
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            aux_q <= 1'b0;
        end else if (I_AUX_FALL) begin
            aux_q <= 1'b0;
        end else if (hit[rae_pkg::EDGE_AUX_RISE]) begin
            aux_q <= 1'b1;
        end
    end

    // rectifiers may conduct only while enabled and inside the ramp window
    assign rect_allow = I_RECT_ENABLE & ramp_gate;

    // gate drive outputs, rectifiers gated by enable and soft start
    // gating is combinational so a disable cuts the drive in the same cycle
    assign O_RECT1 = r1_q & rect_allow;
    assign O_RECT2 = r2_q & rect_allow;
    assign O_AUX   = aux_q;

endmodule : rae_edge_timing

// [verilog/rae_pkg.sv]
// shared constants of the rectifier and auxiliary edge timing block
package rae_pkg;
    // register indices; byte address on the bus is four times the index
    localparam logic [6:0] IDX_R1_FALL_TIME = 7'h53;
    localparam logic [6:0] IDX_R1_FALL_SET  = 7'h54;
    localparam logic [6:0] IDX_R2_RISE_TIME = 7'h55;
    localparam logic [6:0] IDX_R2_RISE_SET  = 7'h56;
    localparam logic [6:0] IDX_R2_FALL_TIME = 7'h57;
    localparam logic [6:0] IDX_R2_FALL_SET  = 7'h58;
    localparam logic [6:0] IDX_AUX_RISE_TIME = 7'h59;
    localparam logic [6:0] IDX_AUX_RISE_SET = 7'h5A;
    localparam logic [6:0] IDX_LATCH        = 7'h5D;
    localparam logic [6:0] IDX_STATUS       = 7'h70;
    // first timing index and number of timing bytes
    localparam logic [6:0] IDX_FIRST        = 7'h53;
    localparam int         NUM_BYTES        = 8;
    localparam int         NUM_EDGES        = 4;
    // edge numbers inside the timing array
    localparam int         EDGE_R1_FALL     = 0;
    localparam int         EDGE_R2_RISE     = 1;
    localparam int         EDGE_R2_FALL     = 2;
    localparam int         EDGE_AUX_RISE    = 3;
    // setting byte field positions
    localparam int         SET_LSB_HI       = 7;
    localparam int         SET_LSB_LO       = 4;
    localparam int         SET_MOD_EN       = 3;
    localparam int         SET_MOD_SIGN     = 2;
    localparam int         SET_RAMP_EVERY   = 1;
    localparam int         SET_RAMP_ON      = 0;
    // latch register strobe bit
    localparam int         LATCH_GO         = 0;
    // status register bit positions
    localparam int         STS_R1           = 0;
    localparam int         STS_R2           = 1;
    localparam int         STS_AUX          = 2;
    localparam int         STS_RAMPING      = 3;
    localparam int         STS_FIRST_DONE   = 4;
    localparam int         STS_PENDING      = 5;
    // reset values and full-scale time
    localparam logic [7:0]  RST_BYTE        = 8'h00;
    localparam logic [11:0] RST_TIME        = 12'h000;
    localparam logic [11:0] TIME_MAX        = 12'hFFF;
    // timing: one edge-time step and the clock period
    localparam int         STEP_NS          = 5;
    localparam int         CLK_NS           = 5;
    localparam int         STEP_CYC         = (STEP_NS + CLK_NS - 1) / CLK_NS;
endpackage : rae_pkg

// [dv/rae_edge_timing_monitor.sv]
// port checker for the edge timing block
`timescale 1ns/100ps
module rae_edge_timing_monitor #(parameter int MOD_W = 8) (
    // clock, reset and bus
    input wire logic             I_CLK,
    input wire logic             I_RSTN,
    input wire logic             I_WB_CYC,
    input wire logic             I_WB_STB,
    input wire logic             I_WB_WE,
    input wire logic [8:0]       I_WB_ADR,
    input wire logic [3:0]       I_WB_SEL,
    input wire logic [31:0]      I_WB_DAT,
    input wire logic [31:0]      O_WB_DAT,
    input wire logic             O_WB_ACK,
    // pwm side and drives
    input wire logic             I_PERIOD_START,
    input wire logic [MOD_W-1:0] I_MODULATION,
    input wire logic             I_RECT_ENABLE,
    input wire logic             I_RECT1_RISE,
    input wire logic             I_AUX_FALL,
    input wire logic             O_RECT1,
    input wire logic             O_RECT2,
    input wire logic             O_AUX
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    // a request not yet answered, and a read of one index answered now
    sequence s_req;
        I_WB_CYC && I_WB_STB && !O_WB_ACK;
    endsequence
    sequence s_rd(idx);
        O_WB_ACK && $past(!I_WB_WE && I_WB_ADR[8:2] == idx);
    endsequence
    // bus answer timing and read data
    a_ack_follows: assert property (s_req |=> O_WB_ACK)
        else $error("ack missing after request");
    a_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(O_WB_ACK) |-> $past(I_WB_CYC && I_WB_STB))
        else $error("ack without request");
    a_upper_zero: assert property (O_WB_ACK |-> O_WB_DAT[31:8] == 24'h00_0000)
        else $error("read data above bit 7 not zero");
    a_go_reads_zero: assert property (
        s_rd(rae_pkg::IDX_LATCH) |-> O_WB_DAT == 32'h0000_0000)
        else $error("strobe register read not zero");
    a_hole_reads_zero: assert property (s_rd(7'h00) |-> O_WB_DAT == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_status_bits: assert property (s_rd(rae_pkg::IDX_STATUS) |-> O_WB_DAT[7:6] == 2'b00)
        else $error("status spare bits set");
    // drive outputs
    a_aux_clear: assert property (I_AUX_FALL |=> !O_AUX)
        else $error("aux drive not cleared");
    a_rect_gated: assert property (!I_RECT_ENABLE |-> !O_RECT1 && !O_RECT2)
        else $error("rectifier drive while disabled");
endmodule : rae_edge_timing_monitor

bind rae_edge_timing rae_edge_timing_monitor #(.MOD_W(MOD_W)) mon_u (
    .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
    .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT),
    .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_PERIOD_START(I_PERIOD_START),
    .I_MODULATION(I_MODULATION), .I_RECT_ENABLE(I_RECT_ENABLE), .I_AUX_FALL(I_AUX_FALL),
    .I_RECT1_RISE(I_RECT1_RISE), .O_RECT1(O_RECT1), .O_RECT2(O_RECT2), .O_AUX(O_AUX));

// [dv/rae_gate_model.sv]
// gate driver model that times each drive edge from period start
`timescale 1ns/100ps
module rae_gate_model (
    // clock, period marker, drives: rect1, rect2, aux
    input  wire logic       i_clk,
    input  wire logic       i_period_start,
    input  wire logic [2:0] i_gate,
    // step count at which each drive last rose and fell
    output int              o_rise_at [3],
    output int              o_fall_at [3]
);
    int         cnt_q;
    logic [2:0] prev_q;
    // step counter restarting each period, one count per 5 ns clock
    always_ff @(posedge i_clk) begin
        cnt_q  <= i_period_start ? 0 : cnt_q + 1;
        prev_q <= i_gate;
        for (int k = 0; k < 3; k++) begin
            if (i_gate[k] && !prev_q[k])
                o_rise_at[k] <= cnt_q;
            if (!i_gate[k] && prev_q[k])
                o_fall_at[k] <= cnt_q;
        end
    end
endmodule : rae_gate_model

// [dv/rae_edge_timing_tb_top.sv]
// self-checking bench for the edge timing block
`timescale 1ns/100ps
module rae_edge_timing_tb_top;
    localparam logic [7:0] TBL [8] = '{8'h01, 8'hF0, 8'h00, 8'h50, 8'h02, 8'h30, 8'h01, 8'h40};
    logic        clk, rst_n, cyc, stb, we, ps, en, r1_rise, a_fall, ack, rect1, rect2, aux;
    logic [8:0]  adr;
    logic [7:0]  mod;
    logic [31:0] wdat, rdat, q;
    int          rise_at [3];
    int          fall_at [3];
    int          error_cnt, num_checks;

    rae_edge_timing #(.MOD_W(8), .RAMP_STEP(1024)) dut_u (
        .I_CLK(clk), .I_RSTN(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
        .I_WB_ADR(adr), .I_WB_SEL(4'h1), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .I_PERIOD_START(ps), .I_MODULATION(mod), .I_RECT_ENABLE(en),
        .I_RECT1_RISE(r1_rise), .I_AUX_FALL(a_fall), .O_RECT1(rect1), .O_RECT2(rect2),
        .O_AUX(aux));
    rae_gate_model gate_u (.i_clk(clk), .i_period_start(ps), .i_gate({aux, rect2, rect1}),
        .o_rise_at(rise_at), .o_fall_at(fall_at));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic results();
        if (error_cnt == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [6:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, idx, 2'b00, 24'h00_0000, d};
        do begin
            @(posedge clk);
            n++;
            if (n > 20) begin
                error_cnt++;
                results();
            end
        end while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask : wb

    task automatic period(input int n);
        @(posedge clk);
        ps <= 1'b1;
        @(posedge clk);
        ps <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : period

    // set rect1, clear aux, then one period
    task automatic run();
        @(posedge clk);
        {r1_rise, a_fall} <= 2'b11;
        @(posedge clk);
        {r1_rise, a_fall} <= 2'b00;
        period(60);
    endtask : run

    task automatic toggle();
        @(posedge clk);
        en <= 1'b0;
        @(posedge clk);
        en <= 1'b1;
        @(posedge clk);
    endtask : toggle

    task automatic t_regs();
        for (int i = 0; i < 8; i++)
            wb(1'b1, 7'(rae_pkg::IDX_FIRST + i), TBL[i]);
        wb(1'b0, rae_pkg::IDX_STATUS, 8'h00);
        check("pending", q & 32'h0000_0020, 32'h0000_0020);
        wb(1'b1, rae_pkg::IDX_LATCH, 8'h01);
        wb(1'b0, rae_pkg::IDX_STATUS, 8'h00);
        check("pending", q & 32'h0000_0020, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            wb(1'b0, 7'(rae_pkg::IDX_FIRST + i), 8'h00);
            check("readback", q, {24'h00_0000, TBL[i]});
        end
        wb(1'b0, 7'h00, 8'h00);
        check("unmapped", q, 32'h0000_0000);
    endtask : t_regs

    task automatic t_edges();
        run();
        check("rect1 fall", fall_at[0], 32);
        check("rect2 rise", rise_at[1], 6);
        check("rect2 fall", fall_at[1], 36);
        check("aux rise", rise_at[2], 21);
        wb(1'b1, rae_pkg::IDX_AUX_RISE_TIME, 8'h03);
        run();
        check("aux unlatched", rise_at[2], 21);
        wb(1'b1, rae_pkg::IDX_AUX_RISE_TIME, 8'h01);
    endtask : t_edges

    task automatic t_mod();
        logic [7:0] mset [3];
        int         mexp [3];
        mset = '{8'h48, 8'h4C, 8'h40};
        mexp = '{11, 31, 21};
        for (int k = 0; k < 3; k++) begin
            wb(1'b1, rae_pkg::IDX_AUX_RISE_SET, mset[k]);
            wb(1'b1, rae_pkg::IDX_LATCH, 8'h01);
            run();
            check("aux modulated", rise_at[2], mexp[k]);
        end
    endtask : t_mod

    task automatic ramp_is(input logic [31:0] exp);
        wb(1'b0, rae_pkg::IDX_STATUS, 8'h00);
        check("ramp status", q & 32'h0000_0018, exp);
    endtask : ramp_is

    task automatic t_ramp();
        wb(1'b1, rae_pkg::IDX_R1_FALL_SET, 8'hF1);
        wb(1'b1, rae_pkg::IDX_LATCH, 8'h01);
        toggle();
        ramp_is(32'h0000_0008);
        repeat (3) period(8);
        ramp_is(32'h0000_0008);
        period(8);
        ramp_is(32'h0000_0010);
        toggle();
        ramp_is(32'h0000_0010);
        wb(1'b1, rae_pkg::IDX_R1_FALL_SET, 8'hF3);
        wb(1'b1, rae_pkg::IDX_LATCH, 8'h01);
        toggle();
        ramp_is(32'h0000_0018);
        wb(1'b1, rae_pkg::IDX_R1_FALL_SET, 8'hF2);
        wb(1'b1, rae_pkg::IDX_LATCH, 8'h01);
        ramp_is(32'h0000_0010);
    endtask : t_ramp

    initial begin
        {cyc, stb, we, ps, r1_rise, a_fall, rst_n, en} = 8'h01;
        adr = 9'h000;
        wdat = 32'h0000_0000;
        mod = 8'h0A;
        error_cnt = 0;
        num_checks = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_edges();
        t_mod();
        t_ramp();
        results();
    end
endmodule : rae_edge_timing_tb_top
